// ### rtl/asrp_regs.svh
// constants for the adc serial readout port: counts, widths and conversion periods
`ifndef ASRP_REGS_SVH
`define ASRP_REGS_SVH
`define ASRP_WORD_BITS      24
`define ASRP_CHANNELS       8
`define ASRP_FRAME_BITS     192
`define ASRP_CLK_PERIOD_NS  40
`define ASRP_PERIOD_MIN     256
`define ASRP_PERIOD_MAX     2560
`define ASRP_PERIOD_HS      256
`define ASRP_PERIOD_HR      512
`define ASRP_PERIOD_LP      512
`define ASRP_PERIOD_LS      2560
`define ASRP_CNT_BITS       12
`define ASRP_DS_MIN_CLK     1
`define ASRP_FIFO_DEPTH     2
`endif

// ### rtl/asrp_pkg.sv
// types shared by the adc serial readout port
package asrp_pkg;
`include "asrp_regs.svh"

  typedef enum logic [1:0] {
    ASRP_HIGH_SPEED,
    ASRP_HIGH_RES,
    ASRP_LOW_POWER,
    ASRP_LOW_SPEED
  } asrp_mode_e;

  typedef enum logic {
    ASRP_COLLECT,
    ASRP_HOLD
  } asrp_state_e;

  typedef logic [`ASRP_WORD_BITS-1:0] asrp_word_t;

  typedef struct packed {
    logic sclk;
    logic frameStrobe;
    logic daisyIn;
  } asrp_link_in_s;

  typedef struct packed {
    logic resultReadyN;
    logic dout;
  } asrp_link_out_s;
endpackage

// ### rtl/asrp_fifo.sv
// small fifo with valid and ready on both sides, data held in registers
`timescale 1ns/100ps
module asrp_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 2
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r   [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0]    wrPtr_r, wrPtr_nxt;
  logic [AW-1:0]    rdPtr_r, rdPtr_nxt;
  logic [AW:0]      count_r, count_nxt;
  logic             push;
  logic             pop;

  // pointer wrap for a depth that need not be a power of two
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // honest full and empty straight from the fill count
  assign inReady  = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData  = mem_r[rdPtr_r];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // next state of storage and pointers
  always_comb begin
    mem_nxt   = mem_r;
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    count_nxt = count_r;
    if (push) begin
      mem_nxt[wrPtr_r] = inData;
      wrPtr_nxt        = bump(wrPtr_r);
    end
    if (pop) begin
      rdPtr_nxt = bump(rdPtr_r);
    end
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      mem_r   <= mem_nxt;
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
  end
endmodule

// ### rtl/asrp_readout_port.sv
// serial readout port of an eight channel converter, spi style and frame strobe formats
//
// Functional notes
// [R1] one result per conversion period of 256 to 2560 clocks, set by mode pins
// [R2] spi style: result ready goes low on a clock edge when a result is new
// [R3] host waits at least one clock after result ready falls before sclk rises
// [R4] spi style: msb is on the data output once result ready falls
// [R5] result ready returns high on a falling sclk edge while shifting out
// [R6] host keeps sclk period at least one clock, each phase at least 0.4
// [R7] data output moves to the next bit on each falling sclk edge
// [R8] daisy chain input is sampled on falling sclk edges
// [R9] frame strobe format: sclk runs continuously at clock divided by 1, 2, 4, 8
// [R10] frame strobe format: sclk falls within a quarter clock of a clock fall
// [R11] frame strobe high and low one sclk period each, once per conversion; the host model holds it high two periods
// [R12] frame strobe format: msb driven in response to a rising frame strobe
// [R13] host clock period 37 to 10000 ns, 30.5 ns only high speed frame strobe
// [R14] above 27 MHz the host uses only the frame strobe format
// [R15] each channel is a 24 bit word, msb first, channels in fixed order
// [R16] past the last channel word the daisy chain bits pass through to the output
`timescale 1ns/100ps
`include "asrp_regs.svh"
module asrp_readout_port #(
  parameter int WORD_BITS  = `ASRP_WORD_BITS,
  parameter int CHANNELS   = `ASRP_CHANNELS,
  parameter int FIFO_DEPTH = `ASRP_FIFO_DEPTH
) (
  input  wire logic                     clock,
  input  wire logic                     resetn,
  input  wire asrp_pkg::asrp_mode_e     perfMode,
  input  wire logic                     clockDividerSel,
  input  wire logic                     frameStrobeFormat,
  input  wire logic                     sampleValid,
  output logic                          sampleReady,
  input  wire logic     [WORD_BITS-1:0] sampleData,
  input  wire asrp_pkg::asrp_link_in_s  linkIn,
  output asrp_pkg::asrp_link_out_s      linkOut
);
  localparam int FB = WORD_BITS * CHANNELS;
  localparam int CW = `ASRP_CNT_BITS;

  logic [CW-1:0]          convCnt_r, convCnt_nxt;
  logic [FB-1:0]          collect_r, collect_nxt;
  logic [3:0]             collected_r, collected_nxt;
  asrp_pkg::asrp_state_e  state_r, state_nxt;
  logic [FB-1:0]          hold_r, hold_nxt;
  logic [FB-1:0]          shift_r, shift_nxt;
  logic                   readyN_r, readyN_nxt;
  logic                   sclkPrev_r;
  logic                   fsPrev_r;
  logic [CW-1:0]          period;
  logic                   tick;
  logic                   sclkFall;
  logic                   fsRise;
  logic                   loadSpi;
  logic                   loadFs;
  logic                   shiftEn;
  logic                   fifoValid;
  logic                   fifoReady;
  logic [WORD_BITS-1:0]   fifoData;
  logic                   pop;

  // conversion period in clocks; clearing the divider select halves it, unless the half would fall below the minimum
  function automatic logic [CW-1:0] periodOf(input asrp_pkg::asrp_mode_e m, input logic div);
    logic [CW-1:0] base;
    logic [CW-1:0] half;
    base = CW'(`ASRP_PERIOD_HS);
    case (m)
      asrp_pkg::ASRP_HIGH_SPEED: base = CW'(`ASRP_PERIOD_HS);
      asrp_pkg::ASRP_HIGH_RES:   base = CW'(`ASRP_PERIOD_HR);
      asrp_pkg::ASRP_LOW_POWER:  base = CW'(`ASRP_PERIOD_LP);
      asrp_pkg::ASRP_LOW_SPEED:  base = CW'(`ASRP_PERIOD_LS);
      default:                   base = CW'(`ASRP_PERIOD_HS);
    endcase
    half = base >> 1;
    if (div || (half < CW'(`ASRP_PERIOD_MIN))) begin
      return base;
    end
    return half;
  endfunction

  // converter words wait here so a late collector loses none
  asrp_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock    (clock),
    .resetn   (resetn),
    .inValid  (sampleValid),
    .inReady  (sampleReady),
    .inData   (sampleData),
    .outValid (fifoValid),
    .outReady (fifoReady),
    .outData  (fifoData)
  );

  // pins are synchronous to the clock, so one flop each is enough for edge detection
  assign period    = periodOf(perfMode, clockDividerSel);
  assign tick      = (convCnt_r == period - 1'b1);                          // [R1]
  assign sclkFall  = sclkPrev_r & ~linkIn.sclk;
  assign fsRise    = ~fsPrev_r & linkIn.frameStrobe;
  assign fifoReady = (state_r == asrp_pkg::ASRP_COLLECT);
  assign pop       = fifoValid & fifoReady;
  assign loadSpi   = !frameStrobeFormat && tick && (state_r == asrp_pkg::ASRP_HOLD);
  assign loadFs    = frameStrobeFormat && fsRise;
  assign shiftEn   = sclkFall && !loadSpi && !loadFs;
  // one driver for the whole output struct, so no tool sees its fields as competing writers
  assign linkOut = '{resultReadyN: readyN_r, dout: shift_r[FB-1]};

  // conversion timer and frame collection; a frame not complete at the tick waits for the next tick
  always_comb begin
    convCnt_nxt   = tick ? '0 : convCnt_r + 1'b1;                           // [R1]
    collect_nxt   = collect_r;
    collected_nxt = collected_r;
    state_nxt     = state_r;
    hold_nxt      = hold_r;
    case (state_r)
      asrp_pkg::ASRP_COLLECT: begin
        if (pop) begin
          collect_nxt   = {collect_r[FB-WORD_BITS-1:0], fifoData};          // [R15]
          collected_nxt = collected_r + 1'b1;
          if (collected_r == 4'(CHANNELS - 1)) begin
            state_nxt = asrp_pkg::ASRP_HOLD;
          end
        end
      end
      asrp_pkg::ASRP_HOLD: begin
        if (tick) begin
          hold_nxt      = collect_r;                                        // [R1]
          collected_nxt = '0;
          state_nxt     = asrp_pkg::ASRP_COLLECT;
        end
      end
      default: begin
        state_nxt = asrp_pkg::ASRP_COLLECT;
      end
    endcase
  end

  // output shifter: a fresh load beats a coincident sclk fall
  always_comb begin
    shift_nxt  = shift_r;
    readyN_nxt = readyN_r;
    if (loadSpi) begin
      shift_nxt  = collect_r;                                               // [R4]
      readyN_nxt = 1'b0;                                                    // [R2]
    end else if (loadFs) begin
      shift_nxt  = hold_r;                                                  // [R12]
    end else if (shiftEn) begin
      shift_nxt  = {shift_r[FB-2:0], linkIn.daisyIn};                       // [R7] [R8] [R16]
      readyN_nxt = 1'b1;                                                    // [R5]
    end
    if (frameStrobeFormat) begin
      readyN_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      convCnt_r   <= '0;
      collect_r   <= '0;
      collected_r <= '0;
      state_r     <= asrp_pkg::ASRP_COLLECT;
      hold_r      <= '0;
      shift_r     <= '0;
      readyN_r    <= 1'b1;
      sclkPrev_r  <= 1'b0;
      fsPrev_r    <= 1'b0;
    end else begin
      convCnt_r   <= convCnt_nxt;
      collect_r   <= collect_nxt;
      collected_r <= collected_nxt;
      state_r     <= state_nxt;
      hold_r      <= hold_nxt;
      shift_r     <= shift_nxt;
      readyN_r    <= readyN_nxt;
      sclkPrev_r  <= linkIn.sclk;
      fsPrev_r    <= linkIn.frameStrobe;
    end
  end

  // helper for checking: clocks since the previous tick
  logic [CW-1:0] gap_r;
  logic          seen_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gap_r  <= '0;
      seen_r <= 1'b0;
    end else begin
      gap_r  <= tick ? '0 : gap_r + 1'b1;
      seen_r <= seen_r | tick;
    end
  end

  property p_period;
    @(posedge clock) disable iff (!resetn)
      (tick && seen_r && $stable(period)) |->
        ((gap_r == period - 1'b1) && (period >= CW'(`ASRP_PERIOD_MIN))
          && (period <= CW'(`ASRP_PERIOD_MAX)));
  endproperty
  a_period: assert property (p_period) else $error("conversion period wrong"); // [R1]

  property p_ready_fall;
    @(posedge clock) disable iff (!resetn)
      loadSpi |=> !linkOut.resultReadyN;
  endproperty
  a_ready_fall: assert property (p_ready_fall) else $error("result ready not low"); // [R2]

  property p_msb_spi;
    @(posedge clock) disable iff (!resetn)
      $fell(linkOut.resultReadyN) |-> (linkOut.dout == $past(collect_r[FB-1]));
  endproperty
  a_msb_spi: assert property (p_msb_spi) else $error("msb missing at ready fall"); // [R4]

  property p_ready_rise;
    @(posedge clock) disable iff (!resetn)
      (!linkOut.resultReadyN && shiftEn) |=> linkOut.resultReadyN;
  endproperty
  a_ready_rise: assert property (p_ready_rise) else $error("result ready not high"); // [R5]

  property p_next_bit;
    @(posedge clock) disable iff (!resetn)
      shiftEn |=> (linkOut.dout == $past(shift_r[FB-2]));
  endproperty
  a_next_bit: assert property (p_next_bit) else $error("output did not advance"); // [R7]

  property p_daisy;
    @(posedge clock) disable iff (!resetn)
      shiftEn |=> (shift_r[0] == $past(linkIn.daisyIn));
  endproperty
  a_daisy: assert property (p_daisy) else $error("daisy bit not taken"); // [R8]

  property p_msb_fs;
    @(posedge clock) disable iff (!resetn)
      loadFs |=> (linkOut.dout == $past(hold_r[FB-1])) && linkOut.resultReadyN;
  endproperty
  a_msb_fs: assert property (p_msb_fs) else $error("msb missing at frame strobe"); // [R12]

  property p_word;
    @(posedge clock) disable iff (!resetn)
      pop |=> (collect_r[WORD_BITS-1:0] == $past(fifoData));
  endproperty
  a_word: assert property (p_word) else $error("channel word not collected"); // [R15]

  property p_still;
    @(posedge clock) disable iff (!resetn)
      (!sclkFall && !loadSpi && !loadFs) |=> $stable(shift_r);
  endproperty
  a_still: assert property (p_still) else $error("output moved without sclk"); // [R16]
endmodule

// ### verification/asrp_host_model.sv
// behavioural host: serial clock, frame strobe and daisy chain source
`timescale 1ns/100ps
module asrp_host_model (
  input  wire logic               clock,
  input  wire logic               dout,
  output asrp_pkg::asrp_link_in_s linkIn
);
  logic got [0:255];

  // sclk stands low between frames
  initial linkIn = '0;

  // one bit: rise, sample, fall; period is four clocks
  // the first rise comes a full clock after the edge the caller saw ready fall on
  task automatic shift_bits(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clock);
      linkIn.sclk    <= 1'b1;
      linkIn.daisyIn <= k[0] ^ k[2]; // stable across the next fall
      @(negedge clock);
      got[k] = dout; // settled since the fall before
      repeat (2) @(posedge clock);
      linkIn.sclk <= 1'b0;
      @(posedge clock);
    end
  endtask

  // sclk never stops in this format: a quarter of the clock, moved on clock falls
  // strobe rises with an sclk fall after lead periods and stays high two periods
  task automatic frame_read(input int lead, input int n);
    for (int t = 0; t < 4 * (lead + n + 1); t++) begin
      @(negedge clock);
      if (t % 4 == 0) begin
        if (t / 4 > lead) got[t / 4 - lead - 1] = dout; // rising sclk samples the bit
        linkIn.sclk <= 1'b1;
      end else if (t % 4 == 2) begin
        linkIn.sclk        <= 1'b0;
        linkIn.frameStrobe <= (t / 4 >= lead) && (t / 4 < lead + 2);
      end
    end
  endtask
endmodule

// ### verification/asrp_readout_port_bench.sv
// self-checking bench for the serial readout port
`timescale 1ns/100ps
module asrp_readout_port_bench;
  typedef struct {
    asrp_pkg::asrp_mode_e mode;
    logic                 div;
    int                   period;
  } asrp_row_s;

  logic                     clock = 1'b0;
  logic                     resetn = 1'b0;
  asrp_pkg::asrp_mode_e     perfMode = asrp_pkg::ASRP_HIGH_SPEED;
  logic                     clockDividerSel = 1'b1;
  logic                     frameStrobeFormat = 1'b0;
  logic                     sampleValid = 1'b0;
  logic                     sampleReady;
  logic [23:0]              sampleData = 24'h3a5c0f;
  asrp_pkg::asrp_link_in_s  linkIn;
  asrp_pkg::asrp_link_out_s linkOut;
  int                       fail_count = 0;
  int                       n_checks = 0;
  int                       wordIdx = 0;
  int                       cnt;
  asrp_row_s                rows [8] = '{
    '{asrp_pkg::ASRP_HIGH_SPEED, 1'b1, 256},
    '{asrp_pkg::ASRP_HIGH_RES, 1'b1, 512},
    '{asrp_pkg::ASRP_LOW_POWER, 1'b1, 512},
    '{asrp_pkg::ASRP_LOW_SPEED, 1'b1, 2560},
    '{asrp_pkg::ASRP_HIGH_SPEED, 1'b0, 256},
    '{asrp_pkg::ASRP_HIGH_RES, 1'b0, 256},
    '{asrp_pkg::ASRP_LOW_POWER, 1'b0, 256},
    '{asrp_pkg::ASRP_LOW_SPEED, 1'b0, 1280}};

  // 40 ns master clock, inside the allowed range and slow enough for spi style
  always #20 clock = ~clock;

  asrp_readout_port uut (.clock(clock), .resetn(resetn), .perfMode(perfMode),
    .clockDividerSel(clockDividerSel), .frameStrobeFormat(frameStrobeFormat),
    .sampleValid(sampleValid), .sampleReady(sampleReady), .sampleData(sampleData),
    .linkIn(linkIn), .linkOut(linkOut));

  asrp_host_model host (.clock(clock), .dout(linkOut.dout), .linkIn(linkIn));

  // distinct word per channel so misordering shows
  function automatic logic [23:0] chanWord(input int c);
    return 24'h3a5c0f ^ (24'h111111 * c[23:0]);
  endfunction

  function automatic logic expBit(input int j);
    logic [23:0] w;
    w = chanWord(j / 24);
    return w[23 - (j % 24)];
  endfunction

  // converter side offers channels 0..7 round and round
  always @(posedge clock) begin
    if (!resetn) begin
      wordIdx    <= 0;
      sampleData <= chanWord(0);
    end else if (sampleValid && sampleReady) begin
      wordIdx    <= (wordIdx + 1) % 8;
      sampleData <= chanWord((wordIdx + 1) % 8);
    end
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    n_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic complete_run;
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // pins are static, so they change only under reset
  task automatic restart(input asrp_pkg::asrp_mode_e m, input logic d, input logic fs);
    @(posedge clock);
    resetn            <= 1'b0;
    sampleValid       <= 1'b0;
    perfMode          <= m;
    clockDividerSel   <= d;
    frameStrobeFormat <= fs;
    repeat (6) @(posedge clock);
    resetn      <= 1'b1;
    sampleValid <= 1'b1;
  endtask

  // bounded wait for result ready to go low
  task automatic wait_fall;
    cnt = 0;
    do begin
      @(negedge clock);
      cnt++;
    end while (linkOut.resultReadyN !== 1'b0 && cnt < 3000);
  endtask

  initial begin
    // the first edge applies reset; before it the registers are still unknown
    @(posedge clock);
    #1;
    check(sampleReady, 1'b1);
    check(linkOut.resultReadyN, 1'b1);
    // fall to fall spacing per mode row; one bit read in between
    foreach (rows[i]) begin
      restart(rows[i].mode, rows[i].div, 1'b0);
      wait_fall();
      check(linkOut.resultReadyN, 1'b0);
      check(linkOut.dout, chanWord(0) >> 23);
      cnt = 0;
      fork
        host.shift_bits(1);
        while (cnt < 3000 && !(cnt > 8 && linkOut.resultReadyN === 1'b0)) begin
          @(negedge clock);
          cnt++;
          if (cnt == 8) check(linkOut.resultReadyN, 1'b1);
        end
      join
      check(24'(cnt), 24'(rows[i].period));
    end
    // collector stops after eight words, so the buffer fills and refuses
    restart(asrp_pkg::ASRP_HIGH_SPEED, 1'b1, 1'b0);
    repeat (40) @(posedge clock);
    #1;
    check(sampleReady, 1'b0);
    // full readout with daisy chain bits behind the last word
    restart(asrp_pkg::ASRP_LOW_SPEED, 1'b1, 1'b0);
    wait_fall();
    host.shift_bits(200);
    for (int j = 0; j < 192; j++) check(host.got[j], expBit(j));
    for (int k = 0; k < 8; k++) check(host.got[192 + k], k[0] ^ k[2]);
    // frame strobe format: ready stays high, msb follows the strobe
    // sclk runs from the release on; the strobe comes after the first tick has latched a frame
    restart(asrp_pkg::ASRP_HIGH_SPEED, 1'b1, 1'b1);
    host.frame_read(75, 24);
    check(linkOut.resultReadyN, 1'b1);
    for (int j = 0; j < 24; j++) check(host.got[j], expBit(j));
    complete_run();
  end

  // all scenarios fit well inside 40000 clocks
  initial begin
    #(40 * 40000);
    fail_count++;
    complete_run();
  end
endmodule
